// *** core/sarseq_core.sv ***
// Conversion sequencer: start handshake, bit-by-bit decisions and output coding.
// Summary of operation
// - Start only after acquisition, on a falling start edge.
// - Decide eighteen bits, most significant first.
// - Form code, then drop busy.
// - Coding select ignored in 18-bit parallel mode.
// - Straight binary: zero input gives 0x20000.
// - Twos complement inverts the top bit.
// - Overrange saturates to maximum code.
// - Underrange saturates to minimum code.
// - Result belongs to this conversion, no latency.
`timescale 1ns/1ps
`include "sarseq_params.svh"
module sarseq_core #(
  parameter int RES_BITS   = `SARSEQ_RES_BITS,
  parameter int ACQ_CYCLES = `SARSEQ_ACQ_CYCLES
) (
  input  wire logic                sys_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                convert_start_n_i,
  input  wire logic                output_coding_select_i,
  input  wire logic                parallel_18bit_mode_i,
  input  wire logic                bit_decision_i,
  input  wire logic                overrange_i,
  input  wire logic                underrange_i,
  output logic                     busy_o,
  output logic                     acquiring_o,
  output logic [RES_BITS-1:0]      trial_code_o,
  output logic [RES_BITS-1:0]      result_o,
  output logic                     result_valid_o
);
  sarseq_pkg::sarseq_state_e state;
  sarseq_pkg::sarseq_state_e next_state;
  logic [4:0]                bit_idx;
  logic [3:0]                acq_cnt;
  logic [RES_BITS-1:0]       trial;
  logic [RES_BITS-1:0]       decided;
  logic                      start_prev;

  wire                       in_acq;
  wire                       in_ready;
  wire                       in_conv;
  wire                       in_code;
  wire                       start_fall;
  wire                       start_taken;
  wire                       acq_done;
  wire                       last_bit;
  wire [4:0]                 lower_idx;
  wire [RES_BITS-1:0]        cur_bit;
  wire [RES_BITS-1:0]        kept;
  wire [RES_BITS-1:0]        final_bits;
  wire [RES_BITS-1:0]        sat_bin;
  wire                       use_twos;
  wire [RES_BITS-1:0]        coded;
  wire [3:0]                 next_acq_cnt;
  wire                       next_acquiring;
  wire [4:0]                 next_bit_idx;
  wire [RES_BITS-1:0]        next_trial;
  wire [RES_BITS-1:0]        next_decided;
  wire                       next_busy;
  wire [RES_BITS-1:0]        next_result;
  wire                       next_valid;

  function automatic logic [RES_BITS-1:0] onehot_bit(input logic [4:0] idx);
    onehot_bit = '0;
    onehot_bit[idx] = 1'b1;
  endfunction : onehot_bit

  function automatic logic [4:0] step_down(input logic [4:0] idx);
    step_down = idx - 5'h1;
  endfunction : step_down

  // Twos complement differs from straight binary only in the top bit.
  function automatic logic [RES_BITS-1:0] to_output_code(
    input logic [RES_BITS-1:0] bin,
    input logic                twos
  );
    to_output_code = twos ? (bin ^ RES_BITS'(`SARSEQ_CODE_MID)) : bin;
  endfunction : to_output_code

  assign in_acq      = (state == sarseq_pkg::SARSEQ_ACQ);
  assign in_ready    = (state == sarseq_pkg::SARSEQ_READY);
  assign in_conv     = (state == sarseq_pkg::SARSEQ_CONV);
  assign in_code     = (state == sarseq_pkg::SARSEQ_CODE);
  // The falling edge is used so a start held low does not retrigger.
  assign start_fall  = start_prev & ~convert_start_n_i;
  // Starts outside READY, including while busy, are dropped.
  assign start_taken = in_ready & start_fall;
  assign acq_done    = (acq_cnt == 4'(ACQ_CYCLES));
  assign last_bit    = (bit_idx == 5'h0);
  assign lower_idx   = step_down(bit_idx);
  assign cur_bit     = onehot_bit(bit_idx);
  // Keep or drop the trial bit from the comparator; a high decision keeps it.
  assign kept        = bit_decision_i ? trial : (trial & ~cur_bit);
  assign final_bits  = last_bit ? kept : decided;
  // Saturation comes from the comparator front end flags of this conversion.
  assign sat_bin     = overrange_i  ? RES_BITS'(`SARSEQ_CODE_POS_FS) :
                       underrange_i ? RES_BITS'(`SARSEQ_CODE_NEG_FS) :
                       decided;
  assign use_twos    = output_coding_select_i & ~parallel_18bit_mode_i;
  assign coded       = to_output_code(sat_bin, use_twos);

  assign next_acq_cnt   = (in_acq && !acq_done) ? acq_cnt + 4'h1 : 4'h0;
  assign next_acquiring = (next_state == sarseq_pkg::SARSEQ_ACQ);
  assign next_bit_idx   = start_taken            ? 5'(`SARSEQ_MSB_POS) :
                          (in_conv && !last_bit) ? lower_idx :
                          bit_idx;
  assign next_trial     = start_taken            ? RES_BITS'(`SARSEQ_CODE_MID) :
                          (in_conv && !last_bit) ? (kept | onehot_bit(lower_idx)) :
                          in_conv                ? kept :
                          trial;
  assign next_decided   = in_conv ? final_bits : decided;
  assign next_busy      = start_taken ? 1'b1 : (in_code ? 1'b0 : busy_o);
  // Result and busy fall change together, so no stale code is seen.
  assign next_result    = in_code ? coded : result_o;
  assign next_valid     = start_taken ? 1'b0 : (in_code ? 1'b1 : result_valid_o);

  always_comb begin
    next_state = state;
    unique case (state)
      sarseq_pkg::SARSEQ_ACQ: begin
        if (acq_done) begin
          next_state = sarseq_pkg::SARSEQ_READY;
        end
      end
      sarseq_pkg::SARSEQ_READY: begin
        if (start_fall) begin
          next_state = sarseq_pkg::SARSEQ_CONV;
        end
      end
      sarseq_pkg::SARSEQ_CONV: begin
        if (last_bit) begin
          next_state = sarseq_pkg::SARSEQ_CODE;
        end
      end
      sarseq_pkg::SARSEQ_CODE: begin
        next_state = sarseq_pkg::SARSEQ_ACQ;
      end
      default: begin
        next_state = sarseq_pkg::SARSEQ_ACQ;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= sarseq_pkg::SARSEQ_ACQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      start_prev <= 1'b1;
    end else begin
      start_prev <= convert_start_n_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acq_cnt <= 4'h0;
    end else begin
      acq_cnt <= next_acq_cnt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acquiring_o <= 1'b1;
    end else begin
      acquiring_o <= next_acquiring;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_idx <= 5'h0;
    end else begin
      bit_idx <= next_bit_idx;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trial <= '0;
    end else begin
      trial <= next_trial;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trial_code_o <= '0;
    end else begin
      trial_code_o <= next_trial;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      decided <= '0;
    end else begin
      decided <= next_decided;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= next_busy;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_o <= '0;
    end else begin
      result_o <= next_result;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_valid_o <= 1'b0;
    end else begin
      result_valid_o <= next_valid;
    end
  end
endmodule : sarseq_core

// *** core/sarseq_params.svh ***
// Constants of the successive-approximation conversion sequencer.
`ifndef SARSEQ_PARAMS_SVH
`define SARSEQ_PARAMS_SVH
`define SARSEQ_RES_BITS      18
`define SARSEQ_CODE_NEG_FS   18'h00000
`define SARSEQ_CODE_MID      18'h20000
`define SARSEQ_CODE_POS_FS   18'h3ffff
`define SARSEQ_MSB_POS       17
`define SARSEQ_ACQ_CYCLES    4
`endif

// *** core/sarseq_pkg.sv ***
// Types of the successive-approximation conversion sequencer.
package sarseq_pkg;
  typedef enum logic [3:0] {
    SARSEQ_ACQ   = 4'b0001,
    SARSEQ_READY = 4'b0010,
    SARSEQ_CONV  = 4'b0100,
    SARSEQ_CODE  = 4'b1000
  } sarseq_state_e;
endpackage : sarseq_pkg

// *** tb/sarseq_assertions.sv ***
// Checker of the sequencer's port timing.
`timescale 1ns/1ps
module sarseq_chk #(
  parameter int RES_BITS = 18
) (
  input wire logic                sys_clk_i,
  input wire logic                nrst_i,
  input wire logic                busy_o,
  input wire logic                acquiring_o,
  input wire logic [RES_BITS-1:0] trial_code_o,
  input wire logic [RES_BITS-1:0] result_o,
  input wire logic                result_valid_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  sequence conv_s;
    busy_o [*8] ##11 busy_o ##1 !busy_o && result_valid_o;
  endsequence
  chk_conv_length: assert property ($rose(busy_o) |-> conv_s) else $error("bad busy");
  chk_first_trial: assert property ($rose(busy_o) |-> trial_code_o == 18'h20000 ##1
    trial_code_o[16]) else $error("bad msb trial");
  chk_trial_lsb: assert property ($rose(busy_o) |-> ##17 trial_code_o[0]) else $error("lsb");
  chk_start_ready: assert property ($rose(busy_o) |-> !$past(acquiring_o)) else $error("st");
  chk_acq_after: assert property ($fell(busy_o) |-> acquiring_o [*4]) else $error("acq");
  chk_result_hold: assert property (result_valid_o [*2] |-> $stable(result_o))
    else $error("result moved");
  chk_busy_acq: assert property (busy_o |-> !acquiring_o) else $error("busy in acq");
  chk_valid_busy: assert property ($rose(result_valid_o) |-> $past(busy_o)) else $error("v");
endmodule : sarseq_chk

// *** tb/sarseq_host.sv ***
// Host model that requests conversions.
`timescale 1ns/1ps
module sarseq_host (
  input  wire logic sys_clk_i,
  input  wire logic go_i,
  input  wire logic acquiring_i,
  output logic      convert_start_n_o
);
  initial convert_start_n_o = 1'b1;
  // Pulses go on during busy on purpose, so that ignored starts are exercised.
  always @(posedge sys_clk_i) #1 convert_start_n_o = !(go_i && !acquiring_i && convert_start_n_o);
endmodule : sarseq_host

// *** tb/sar_conversion_sequencer_test.sv ***
// Bench of the conversion sequencer.
`timescale 1ns/1ps
module sar_conversion_sequencer_test;
  logic clk, nrst, go, sel, mode, ov, un, st_n, busy, acq, valid;
  logic [17:0] tgt, trial, res;
  logic [39:0] rows [9] = '{{18'h20000, 4'h0, 18'h20000}, {18'h20000, 4'h8, 18'h00000},
    {18'h3fffe, 4'h8, 18'h1fffe}, {18'h00001, 4'h8, 18'h20001}, {18'h12345, 4'hc, 18'h12345},
    {18'h00000, 4'ha, 18'h1ffff}, {18'h3ffff, 4'h1, 18'h00000}, {18'h00000, 4'h2, 18'h3ffff},
    {18'h3ffff, 4'h9, 18'h20000}};
  int n_errors = 0, num_checks = 0, cyc = 0;
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  sarseq_host host_u (.sys_clk_i(clk), .go_i(go), .acquiring_i(acq), .convert_start_n_o(st_n));
  sarseq_core dut_u (.sys_clk_i(clk), .nrst_i(nrst), .convert_start_n_i(st_n),
    .output_coding_select_i(sel), .parallel_18bit_mode_i(mode), .bit_decision_i(tgt >= trial),
    .overrange_i(ov), .underrange_i(un), .busy_o(busy), .acquiring_o(acq),
    .trial_code_o(trial), .result_o(res), .result_valid_o(valid));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  always @(posedge clk) if (++cyc > 1000) begin
    n_errors++;
    final_report();
  end
  initial begin
    {nrst, go, tgt, sel, mode, ov, un} = '0;
    repeat (3) @(posedge clk);
    #1 nrst = 1;
    foreach (rows[i]) begin
      {tgt, sel, mode, ov, un} = rows[i][39:18];
      go = 1;
      @(posedge valid) #1 go = 0;
      chk(res, rows[i][17:0]);
      $display("row %0d done", i);
    end
    go = 1;
    @(posedge busy) #1 nrst = 0;
    #1 chk({busy, valid, acq, res[14:0]}, 18'h08000);
    $display("reset test done");
    @(posedge clk) #1 nrst = 1;
    @(posedge clk) #1 chk({16'h0000, busy, acq}, 18'h00001);
    {tgt, sel, mode, ov, un} = rows[2][39:18];
    @(posedge valid) #1 chk(res, rows[2][17:0]);
    $display("reset release test done");
    final_report();
  end
endmodule : sar_conversion_sequencer_test
bind sarseq_core sarseq_chk #(.RES_BITS(RES_BITS)) chk_u (.sys_clk_i, .nrst_i, .busy_o,
  .acquiring_o, .trial_code_o, .result_o, .result_valid_o);
